// [card_control_channel_enable_regs.v]
`include "card_regs_defs.vh"

// What this block does
// - identifier bits 7:0 mark base board mod
// - identifier bits 15:8 mark front-end mod
// - identifier bits 23:16 mark hub module mod
// - standard card reads all-zero modification fields
// - writing reset code to command register resets card
// - command reset acts like power-on reset, except interrupt status is kept
// - all settings, channel bitmap included, return default
// - memory data flagged invalid after reset command
// - reset command disables trigger and clock outputs
// - channel bitmap takes effect at next run start
// - bit 0 enables channel 0, bit 1 channel 1
// - only masks 1, 2, 3 accepted; others flagged error
// - read-only count of enabled channels
// - bitmap and count readable right after write
module card_control_channel_enable_regs #(
	parameter [7:0] BASE_MOD_CODE = 8'h00, // arbitrary, zero on standard card
	parameter [7:0] FRONT_MOD_CODE = 8'h00, // arbitrary, zero on standard card
	parameter [7:0] HUB_MOD_CODE = 8'h00 // arbitrary, zero on standard card
) (
	// clock and reset
	input wire clk_sys,
	input wire sys_rst,
	// register port
	input wire [`ADDR_W-1:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// acquisition engine
	input wire run_done,
	output reg run_active,
	output reg [1:0] run_chan_enable,
	output reg mem_data_valid,
	// card outputs
	output reg clk_out_en,
	output reg trig_out_en,
	// interrupt
	output wire irq
);

	wire [15:0] idx; // word index from byte address
	wire rst_int; // power-on or command reset
	wire cmd_reset; // one-cycle reset command pulse
	wire wr_cmd, wr_chen, wr_stat, wr_mask, wr_ctrl;
	wire chen_ok; // written mask is legal
	wire [`IRQ_BITS-1:0] irq_evt; // event pulses
	reg [1:0] chen_r; // programmed channel bitmap
	reg [1:0] chen_nxt;
	reg [1:0] chcount_r; // channel count of the programmed bitmap
	reg [1:0] chcount_nxt;
	reg [`IRQ_BITS-1:0] stat_r; // sticky interrupt status
	reg [`IRQ_BITS-1:0] mask_r; // interrupt mask
	reg rst_evt_r; // remembers a command reset for the status flag
	reg [31:0] rdata_nxt;

	assign idx = reg_addr[`ADDR_W-1:`IDX_LSB];

	// write decodes
	assign wr_cmd = reg_wr & (idx == `IDX_BOARD_COMMAND);
	assign wr_chen = reg_wr & (idx == `IDX_CHAN_ENABLE);
	assign wr_stat = reg_wr & (idx == `IDX_IRQ_STATUS);
	assign wr_mask = reg_wr & (idx == `IDX_IRQ_MASK);
	assign wr_ctrl = reg_wr & (idx == `IDX_RUN_CTRL);

	// only the reset code triggers; other command values are ignored
	assign cmd_reset = wr_cmd & (reg_wdata == `CMD_FULL_RESET);

	// soft reset is stretched and merged with power-on reset
	reset_pulse u_reset_pulse (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.trig(cmd_reset),
		.rst_out(rst_int)
	);

	// legal masks only; upper bits must be zero
	assign chen_ok = (reg_wdata == {30'h0, `CHEN_FIRST}) |
		(reg_wdata == {30'h0, `CHEN_SECOND}) |
		(reg_wdata == {30'h0, `CHEN_BOTH});

	// next bitmap and count: count follows the stored bitmap immediately
	always @* begin
		chen_nxt = chen_r;
		chcount_nxt = chcount_r;
		if (wr_chen && chen_ok) begin
			chen_nxt = reg_wdata[1:0];
			// popcount of the legal mask
			chcount_nxt = {1'b0, reg_wdata[0]} + {1'b0, reg_wdata[1]};
		end
	end

	// channel settings; reset to one channel enabled
	always @(posedge clk_sys) begin
		if (rst_int) begin
			chen_r <= `CHEN_RESET;
			chcount_r <= 2'h1;
		end else begin
			chen_r <= chen_nxt;
			chcount_r <= chcount_nxt;
		end
	end

	// run control: the engine only sees the bitmap latched at run start,
	// so a write during a run cannot disturb channels mid-acquisition
	always @(posedge clk_sys) begin
		if (rst_int) begin
			run_active <= 1'b0;
			run_chan_enable <= `CHEN_RESET;
			mem_data_valid <= 1'b0;
			clk_out_en <= 1'b0;
			trig_out_en <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				clk_out_en <= reg_wdata[`RUN_CLKOUT_BIT];
				trig_out_en <= reg_wdata[`RUN_TRIGOUT_BIT];
			end
			if (wr_ctrl && reg_wdata[`RUN_START_BIT] && !run_active) begin
				run_active <= 1'b1;
				// a write in this same cycle already counts for this run
				run_chan_enable <= chen_nxt;
				mem_data_valid <= 1'b0; // old data stale once a new run starts
			end else if (run_active && (run_done ||
				(wr_ctrl && reg_wdata[`RUN_STOP_BIT]))) begin
				run_active <= 1'b0;
				mem_data_valid <= 1'b1;
			end
		end
	end

	// command reset event survives the internal reset so software can see it
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			rst_evt_r <= 1'b0;
		end else begin
			rst_evt_r <= cmd_reset;
		end
	end

	// event pulses
	assign irq_evt[`IRQ_BAD_MASK] = wr_chen & ~chen_ok;
	assign irq_evt[`IRQ_CARD_RESET] = rst_evt_r;
	assign irq_evt[`IRQ_RUN_DONE] = run_active & run_done;

	// sticky status, write one to clear, set wins over clear
	genvar g;
	generate
		for (g = 0; g < `IRQ_BITS; g = g + 1) begin : g_stat
			always @(posedge clk_sys) begin
				if (sys_rst) begin
					stat_r[g] <= 1'b0;
				end else if (irq_evt[g]) begin
					stat_r[g] <= 1'b1;
				end else if (wr_stat && reg_wdata[g]) begin
					stat_r[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// mask is a setting and returns to all-off on either reset
	always @(posedge clk_sys) begin
		if (rst_int) begin
			mask_r <= {`IRQ_BITS{1'b0}};
		end else if (wr_mask) begin
			mask_r <= reg_wdata[`IRQ_BITS-1:0];
		end
	end

	assign irq = |(stat_r & mask_r);

	// read mux; command register is write-only and reads zero
	always @* begin
		rdata_nxt = 32'h0000_0000;
		case (idx)
			`IDX_CUSTOM_ID: begin
				rdata_nxt[`BASE_MOD_LSB +: 8] = BASE_MOD_CODE;
				rdata_nxt[`FRONT_MOD_LSB +: 8] = FRONT_MOD_CODE;
				rdata_nxt[`HUB_MOD_LSB +: 8] = HUB_MOD_CODE;
			end
			`IDX_CHAN_ENABLE: begin
				rdata_nxt[1:0] = chen_r;
			end
			`IDX_CHAN_COUNT: begin
				rdata_nxt[1:0] = chcount_r;
			end
			`IDX_IRQ_STATUS: begin
				rdata_nxt[`IRQ_BITS-1:0] = stat_r;
			end
			`IDX_IRQ_MASK: begin
				rdata_nxt[`IRQ_BITS-1:0] = mask_r;
			end
			`IDX_RUN_CTRL: begin
				rdata_nxt[`RUN_CLKOUT_BIT] = clk_out_en;
				rdata_nxt[`RUN_TRIGOUT_BIT] = trig_out_en;
			end
			`IDX_RUN_STATUS: begin
				rdata_nxt[0] = run_active;
				rdata_nxt[1] = mem_data_valid;
			end
			default: begin
				rdata_nxt = 32'h0000_0000; // unmapped reads zero
			end
		endcase
	end

	// read data stands one cycle after the strobe, zero otherwise
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			reg_rdata <= rdata_nxt;
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

endmodule

// [card_control_channel_enable_regs_tb.sv]
`include "card_regs_defs.vh"
// counts every compare, reports and counts each mismatch
`define CHK(a, b) begin checks_done++; \
	if ((a) !== (b)) begin fail_count++; $display("[ERR] %0t got %0h", $time, a); end end
module card_control_channel_enable_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [17:0] reg_addr = '0;
	logic [31:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic run_done = 1'b0;
	wire [31:0] reg_rdata;
	wire [1:0] run_chan_enable;
	wire run_active, mem_data_valid, clk_out_en, trig_out_en, irq;
	int fail_count = 0;
	int checks_done = 0;
	always #12.5 clk_sys = ~clk_sys;
	// mod codes are arbitrary, distinct per byte so a swapped field shows
	card_control_channel_enable_regs #(.BASE_MOD_CODE(8'h5a), .FRONT_MOD_CODE(8'hc3),
		.HUB_MOD_CODE(8'h96)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.run_done(run_done), .run_active(run_active), .run_chan_enable(run_chan_enable),
		.mem_data_valid(mem_data_valid), .clk_out_en(clk_out_en), .trig_out_en(trig_out_en),
		.irq(irq));
	// one-cycle write strobe
	task automatic wr(input logic [15:0] i, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= {i, 2'b00};
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// read; now skips the wait so it can follow a write with no gap
	task automatic rd(input logic [15:0] i, input logic [31:0] e, input bit now = 1'b0);
		if (!now) @(posedge clk_sys);
		reg_addr <= {i, 2'b00};
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 `CHK(reg_rdata, e)
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic t_defaults;
		rd(`IDX_CUSTOM_ID, 32'h0096c35a);
		rd(`IDX_BOARD_COMMAND, 32'h0);
		rd(`IDX_CHAN_ENABLE, 32'h1);
		rd(`IDX_CHAN_COUNT, 32'h1);
	endtask
	// every legal mask, then illegal ones that must leave 3 in place
	task automatic t_chen;
		logic [31:0] bad [3] = '{32'h0, 32'h4, 32'h7};
		for (int m = 1; m < 4; m++) begin
			wr(`IDX_CHAN_ENABLE, 32'(m));
			rd(`IDX_CHAN_ENABLE, 32'(m), 1'b1);
			rd(`IDX_CHAN_COUNT, 32'(m[0]) + 32'(m[1]));
		end
		wr(`IDX_CHAN_ENABLE, 32'h3);
		rd(`IDX_CHAN_COUNT, 32'h2, 1'b1);
		foreach (bad[k]) begin
			wr(`IDX_CHAN_ENABLE, bad[k]);
			rd(`IDX_CHAN_ENABLE, 32'h3, 1'b1);
		end
		rd(`IDX_CHAN_COUNT, 32'h2);
		rd(`IDX_IRQ_STATUS, 32'h1);
		`CHK(irq, 1'b0)
		wr(`IDX_IRQ_MASK, 32'h1);
		#1 `CHK(irq, 1'b1)
		wr(`IDX_IRQ_STATUS, 32'h1);
		#1 `CHK(irq, 1'b0)
	endtask
	// bitmap is latched at run start only
	task automatic t_run;
		wr(`IDX_CHAN_ENABLE, 32'h2);
		wr(`IDX_RUN_CTRL, 32'h1);
		#1 `CHK(run_chan_enable, 2'h2)
		wr(`IDX_CHAN_ENABLE, 32'h3);
		#1 `CHK(run_chan_enable, 2'h2)
		@(posedge clk_sys);
		run_done <= 1'b1;
		@(posedge clk_sys);
		run_done <= 1'b0;
		#1 `CHK({run_active, mem_data_valid}, 2'b01)
		wr(`IDX_RUN_CTRL, 32'h1);
		#1 `CHK(run_chan_enable, 2'h3)
	endtask
	// outputs on, run busy, mask set: the reset command clears it all
	task automatic t_cmd;
		wr(`IDX_RUN_CTRL, 32'hc);
		wr(`IDX_IRQ_MASK, 32'h7);
		wr(`IDX_BOARD_COMMAND, 32'h2);
		#1 `CHK({clk_out_en, trig_out_en, run_active}, 3'b111)
		wr(`IDX_BOARD_COMMAND, `CMD_FULL_RESET);
		repeat (5) @(posedge clk_sys);
		#1 `CHK({clk_out_en, trig_out_en, run_active, mem_data_valid, irq}, 5'h0)
		`CHK(run_chan_enable, 2'h1)
		rd(`IDX_CHAN_COUNT, 32'h1);
		rd(`IDX_IRQ_MASK, 32'h0);
		rd(`IDX_IRQ_STATUS, 32'h6);
	endtask
	initial begin
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		// host side: the first driver load always issues a reset command
		wr(`IDX_BOARD_COMMAND, `CMD_FULL_RESET);
		repeat (5) @(posedge clk_sys);
		rd(`IDX_IRQ_STATUS, 32'h2);
		wr(`IDX_IRQ_STATUS, 32'h2);
		t_defaults();
		t_chen();
		t_run();
		t_cmd();
		complete_run();
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		complete_run();
	end
endmodule
bind card_control_channel_enable_regs card_regs_properties chk (.clk_sys(clk_sys),
	.sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .run_done(run_done), .run_active(run_active),
	.run_chan_enable(run_chan_enable), .mem_data_valid(mem_data_valid),
	.clk_out_en(clk_out_en), .trig_out_en(trig_out_en), .irq(irq));

// [card_regs_defs.vh]
`ifndef CARD_REGS_DEFS_VH
`define CARD_REGS_DEFS_VH

// register indices as printed; byte address is four times the index
`define IDX_BOARD_COMMAND 16'h0064
`define IDX_CUSTOM_ID 16'h0c3a
`define IDX_CHAN_ENABLE 16'h2af8
`define IDX_CHAN_COUNT 16'h2af9
// own registers: interrupt status, mask, run control/status
`define IDX_IRQ_STATUS 16'h3000
`define IDX_IRQ_MASK 16'h3001
`define IDX_RUN_CTRL 16'h3002
`define IDX_RUN_STATUS 16'h3003

// byte address width and index slice
`define ADDR_W 18
`define IDX_LSB 2

// board command codes
`define CMD_FULL_RESET 32'h0000_0001

// customisation identifier field positions
`define BASE_MOD_LSB 0
`define FRONT_MOD_LSB 8
`define HUB_MOD_LSB 16

// channel enable masks
`define CHEN_FIRST 2'h1
`define CHEN_SECOND 2'h2
`define CHEN_BOTH 2'h3
`define CHEN_RESET 2'h1

// interrupt status bit positions
`define IRQ_BAD_MASK 0
`define IRQ_CARD_RESET 1
`define IRQ_RUN_DONE 2
`define IRQ_BITS 3

// run control bits
`define RUN_START_BIT 0
`define RUN_STOP_BIT 1
`define RUN_CLKOUT_BIT 2
`define RUN_TRIGOUT_BIT 3

// length of the internal reset pulse after a reset command, in cycles
`define SOFT_RST_CYCLES 4'h4

`endif

// [card_regs_properties.sv]
// watches the register port and the card outputs of the register block
module card_regs_properties (
	input logic clk_sys,
	input logic sys_rst,
	input logic [17:0] reg_addr,
	input logic [31:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	input logic [31:0] reg_rdata,
	input logic run_done,
	input logic run_active,
	input logic [1:0] run_chan_enable,
	input logic mem_data_valid,
	input logic clk_out_en,
	input logic trig_out_en,
	input logic irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// word index and the reset command strobe
	wire [15:0] idx = reg_addr[17:2];
	wire cmd_rst = reg_wr && idx == 16'h0064 && reg_wdata == 32'h1;
	// a two-channel write, then a count read right behind it
	sequence wr_both; reg_wr && idx == 16'h2af8 && reg_wdata == 32'h3; endsequence
	sequence rd_cnt; reg_rd && idx == 16'h2af9; endsequence
	// the internal reset first acts at the edge after the command write, so its effect is sampled two edges on
	a_outs_off: assert property (cmd_rst |-> ##2 (!clk_out_en && !trig_out_en)[*4])
		else $error("card outputs enabled after reset command");
	a_mem_invalid: assert property (cmd_rst |-> ##2 !mem_data_valid && !run_active)
		else $error("memory still valid after reset command");
	a_chan_default: assert property (cmd_rst |-> ##2 run_chan_enable == 2'h1)
		else $error("channel bitmap not default after reset command");
	a_cmd_other: assert property (reg_wr && idx == 16'h0064 && reg_wdata != 32'h1
		&& clk_out_en |=> clk_out_en)
		else $error("unknown command disturbed the card");
	a_cmd_wo: assert property (reg_rd && idx == 16'h0064 |=> reg_rdata == 32'h0)
		else $error("command register readable");
	a_run_hold: assert property (run_active && $past(run_active) |-> $stable(run_chan_enable))
		else $error("bitmap changed during a run");
	a_count_read: assert property (wr_both ##1 rd_cnt |=> reg_rdata == 32'h2)
		else $error("count not updated right after write");
	a_run_end: assert property (run_active && run_done && !reg_wr
		|=> !run_active && mem_data_valid)
		else $error("run did not finish with valid data");
endmodule

// [reset_pulse.v]
`include "card_regs_defs.vh"

// stretches the one-cycle reset command into a fixed-length reset level,
// so every reset consumer sees it like a power-on reset, held for SOFT_RST_CYCLES cycles
module reset_pulse (
	// clock and reset
	input wire clk_sys,
	input wire sys_rst,
	// one-cycle request
	input wire trig,
	// combined reset level
	output wire rst_out
);

	reg [3:0] cnt_r; // remaining cycles of soft reset
	reg [3:0] cnt_nxt;

	// next count: reload on trigger, count down otherwise
	always @* begin
		cnt_nxt = cnt_r;
		if (trig) begin
			cnt_nxt = `SOFT_RST_CYCLES;
		end else if (cnt_r != 4'h0) begin
			cnt_nxt = cnt_r - 4'h1;
		end
	end

	// counter register
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			cnt_r <= 4'h0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// power-on reset and soft reset act the same downstream
	assign rst_out = sys_rst | (cnt_r != 4'h0);

endmodule
